/* tsi_pkg.sv */
// Shared constants and types of the connection control block
package tsi_pkg;
  // Geometry
  localparam int NUM_STREAMS = 16;
  localparam int NUM_CHANS   = 128;
  localparam int POS_W       = 12;
  localparam int CONN_DEPTH  = NUM_STREAMS * NUM_CHANS;

  // Register byte offsets; bit 13 set selects connection words
  localparam logic [13:0] CTRL_OFS   = 14'h0000;
  localparam logic [13:0] OFFSET_OFS = 14'h0004;
  localparam logic [13:0] MEAS_OFS   = 14'h0014;
  localparam int          CONN_SEL_BIT = 13;

  // Control register fields
  localparam int          RATE_LSB     = 0;
  localparam int          GCI_BIT      = 2;
  localparam int          MEAS_GO_BIT  = 3;
  localparam int          MEAS_SEL_LSB = 4;
  localparam logic [31:0] CTRL_RESET   = 32'h00000002;
  localparam logic [31:0] CTRL_GO_MASK = 32'h00000008;

  // Rate codes, cell length as log2 of clocks, channel masks
  localparam logic [1:0] RATE_2M      = 2'h0;
  localparam logic [1:0] RATE_4M      = 2'h1;
  localparam logic [2:0] SHIFT_2M     = 3'h4;
  localparam logic [2:0] SHIFT_4M     = 3'h3;
  localparam logic [2:0] SHIFT_8M     = 3'h2;
  localparam logic [2:0] CHAN_SHIFT   = 3'h3;
  localparam logic [6:0] CHAN_MASK_2M = 7'h1F;
  localparam logic [6:0] CHAN_MASK_4M = 7'h3F;
  localparam logic [6:0] CHAN_MASK_8M = 7'h7F;
  localparam logic [2:0] LAST_BIT     = 3'h7;

  // Frame delay measurement, counted in half periods, one per clock
  localparam logic [3:0]  HALF_MAX      = 4'h9;
  localparam logic [2:0]  COUNT_MAX     = 3'h4;
  localparam int          MEAS_FLAG_BIT = 3;
  localparam int          MEAS_BUSY_BIT = 4;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // One connection word
  typedef struct packed {
    logic       channel_loopback;
    logic       const_delay;
    logic       processor_byte_select;
    logic       control_channel_bit;
    logic       out_enable;
    logic [3:0] source_stream_number;
    logic [6:0] source_channel_number;
  } conn_word_t;

  typedef enum logic [1:0] {MEAS_IDLE, MEAS_ARMED, MEAS_COUNT} meas_state_t;
endpackage

/* stream_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
module stream_receiver (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Frame timing
  input  wire logic [11:0]  pos,
  input  wire logic [2:0]   shift,
  input  wire logic [3:0]   half_shift,
  // Serial data
  input  wire logic         rx_bit,
  input  wire logic         loop_bit,
  input  wire logic [127:0] channel_loopback_row,
  // Read port for the switch
  input  wire logic [6:0]   rd_chan,
  input  wire logic         rd_const,
  output logic      [7:0]   rd_byte
);
  logic [11:0] lpos;
  logic [11:0] phase;
  logic [6:0]  lchan;
  logic [2:0]  lbit;
  logic        sample;
  logic        in_bit;
  logic [7:0]  shreg;
  logic [7:0]  latest [128];
  logic [7:0]  held [128];

  // Local frame position lags by whole and half periods
  assign lpos   = pos - 12'(half_shift);
  assign lchan  = 7'(lpos >> (shift + tsi_pkg::CHAN_SHIFT));
  assign lbit   = 3'(lpos >> shift);
  assign phase  = lpos & 12'((12'h1 << shift) - 12'h1);
  // Sample at three quarters of the cell
  assign sample = phase == 12'(12'h3 << (shift - 3'h2));
  // Looped channels only line up with a zero offset
  assign in_bit = channel_loopback_row[lchan] ? loop_bit : rx_bit;

  // Bit assembly, first bit is the most significant
  always_ff @(posedge clk) begin
    if (rst) begin
      shreg <= 8'h00;
    end else if (sample) begin
      shreg <= {shreg[6:0], in_bit};
    end
  end

  // Latest bytes, plus a frame snapshot for constant delay
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 128; i++) begin
        latest[i] <= 8'h00;
        held[i]   <= 8'h00;
      end
    end else begin
      if (sample && lbit == tsi_pkg::LAST_BIT) begin
        latest[lchan] <= {shreg[6:0], in_bit};
      end
      if (lpos == 12'h000) begin
        held <= latest;
      end
    end
  end

  assign rd_byte = rd_const ? held[rd_chan] : latest[rd_chan];

  loop_take_a: assert property (@(posedge clk) disable iff (rst)
    sample && channel_loopback_row[lchan] |=> shreg[0] == $past(loop_bit))
    else $error("loopback bit not taken from transmit side");
endmodule
`default_nettype wire

/* tdm_switch_connection_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tdm_switch_connection_control (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM register slave
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial line side
  input  wire logic        frame_pulse_input_n,
  input  wire logic [15:0] rx,
  output logic      [15:0] tx,
  output logic      [15:0] tx_oe_n,
  output logic             control_channel_out
);
  // Log2 of clocks per bit cell
  function automatic logic [2:0] cell_shift(input logic [1:0] rate);
    case (rate)
      tsi_pkg::RATE_2M: cell_shift = tsi_pkg::SHIFT_2M;
      tsi_pkg::RATE_4M: cell_shift = tsi_pkg::SHIFT_4M;
      default:          cell_shift = tsi_pkg::SHIFT_8M;
    endcase
  endfunction

  // Channel address bits in use at a rate
  function automatic logic [6:0] chan_mask(input logic [1:0] rate);
    case (rate)
      tsi_pkg::RATE_2M: chan_mask = tsi_pkg::CHAN_MASK_2M;
      tsi_pkg::RATE_4M: chan_mask = tsi_pkg::CHAN_MASK_4M;
      default:          chan_mask = tsi_pkg::CHAN_MASK_8M;
    endcase
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  endfunction

  logic [1:0]          fp_sync;
  logic                fp_last;
  logic                frame_start;
  logic [15:0]         rx_meta;
  logic [15:0]         rx_sync;
  logic [15:0]         rx_last;
  logic [15:0]         rx_prev;
  logic [11:0]         pos;
  logic [31:0]         ctrl;
  logic [1:0]          rate;
  logic [2:0]          shift;
  logic [6:0]          chan;
  logic [6:0]          nxt_chan;
  logic [2:0]          bit_idx;
  logic [3:0]          step;
  logic                bnd;
  logic [15:0]         ofs_reg [4];
  logic [3:0]          half_shift [16];
  tsi_pkg::conn_word_t conn_mem [tsi_pkg::CONN_DEPTH];
  logic [127:0]        channel_loopback_map [16];
  logic [13:0]         word_addr;
  logic [10:0]         cidx;
  logic [1:0]          ofs_idx;
  logic                conn_hit;
  logic                ctrl_hit;
  logic                ofs_hit;
  logic                meas_hit;
  logic                wr_take;
  logic                rd_first;
  logic [15:0]         conn_new;
  logic [31:0]         rd_mux;
  tsi_pkg::conn_word_t w;
  logic [6:0]          rd_chan;
  logic [7:0]          rx_byte [16];
  logic [7:0]          sel_byte;
  logic [7:0]          nxt_byte [16];
  logic [15:0]         nxt_oe;
  logic [7:0]          cur_byte [16];
  logic [15:0]         cur_oe;
  logic [7:0]          out_byte [16];
  logic [15:0]         out_oe;
  tsi_pkg::meas_state_t mstate;
  logic [3:0]          mcnt;
  logic [3:0]          meas_sel;
  logic [2:0]          meas_count;
  logic                meas_flag;
  logic                meas_go;
  logic                rx_fall;

  // Two-stage synchronisers; rx takes a third stage so data and frame
  // start see equal latency, else samples land one clock late
  always_ff @(posedge clk) begin
    if (rst) begin
      fp_sync <= 2'h3;
      fp_last <= 1'b1;
      rx_meta <= 16'hFFFF;
      rx_sync <= 16'hFFFF;
      rx_last <= 16'hFFFF;
      rx_prev <= 16'hFFFF;
    end else begin
      fp_sync <= {fp_sync[0], frame_pulse_input_n};
      fp_last <= fp_sync[1];
      rx_meta <= rx;
      rx_sync <= rx_meta;
      rx_last <= rx_sync;
      rx_prev <= rx_last;
    end
  end

  assign frame_start = fp_last && !fp_sync[1];

  // Frame position in clocks; free runs if pulses go missing
  always_ff @(posedge clk) begin
    if (rst || frame_start) begin
      pos <= 12'h000;
    end else begin
      pos <= pos + 12'h001;
    end
  end

  // Frame timing decode
  assign rate     = ctrl[tsi_pkg::RATE_LSB +: 2];
  assign shift    = cell_shift(rate);
  assign chan     = 7'(pos >> (shift + tsi_pkg::CHAN_SHIFT));
  assign bit_idx  = 3'(pos >> shift);
  assign step     = 4'(pos >> (shift - 3'h1));
  assign bnd      = (bit_idx == 3'h0) &&
                    ((pos & 12'((12'h1 << shift) - 12'h1)) == 12'h000);
  assign nxt_chan = (chan + 7'h01) & chan_mask(rate);

  // Register decode
  assign word_addr = {avs_address[13:2], 2'h0};
  assign cidx      = avs_address[12:2];
  assign conn_hit  = avs_address[tsi_pkg::CONN_SEL_BIT];
  assign ctrl_hit  = !conn_hit && word_addr == tsi_pkg::CTRL_OFS;
  assign ofs_hit   = !conn_hit && word_addr >= tsi_pkg::OFFSET_OFS &&
                     word_addr < tsi_pkg::MEAS_OFS;
  assign meas_hit  = !conn_hit && word_addr == tsi_pkg::MEAS_OFS;
  assign ofs_idx   = 2'((word_addr - tsi_pkg::OFFSET_OFS) >> 2);
  assign wr_take   = avs_write && !avs_waitrequest;
  assign rd_first  = avs_read && avs_waitrequest;
  assign conn_new  = 16'(merge({16'h0000, conn_mem[cidx]}, avs_writedata,
                               avs_byteenable));

  // One wait state per access keeps the read data registered
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data mux, unmapped words read as zero
  always_comb begin
    rd_mux = tsi_pkg::UNMAPPED_DATA;
    if (conn_hit) begin
      rd_mux = {16'h0000, conn_mem[cidx]};
    end else if (ctrl_hit) begin
      rd_mux = ctrl;
    end else if (ofs_hit) begin
      rd_mux = {16'h0000, ofs_reg[ofs_idx]};
    end else if (meas_hit) begin
      rd_mux = tsi_pkg::UNMAPPED_DATA;
      rd_mux[2:0] = meas_count;
      rd_mux[tsi_pkg::MEAS_FLAG_BIT] = meas_flag;
      rd_mux[tsi_pkg::MEAS_BUSY_BIT] = mstate != tsi_pkg::MEAS_IDLE;
    end
  end

  // Read data stands from the first edge until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_first) begin
      avs_readdata <= rd_mux;
    end
  end

  // Control and offset registers; go bit never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= tsi_pkg::CTRL_RESET;
      for (int i = 0; i < 4; i++) begin
        ofs_reg[i] <= 16'h0000;
      end
    end else if (wr_take && ctrl_hit) begin
      ctrl <= merge(ctrl, avs_writedata, avs_byteenable) &
              ~tsi_pkg::CTRL_GO_MASK;
    end else if (wr_take && ofs_hit) begin
      ofs_reg[ofs_idx] <= 16'(merge({16'h0000, ofs_reg[ofs_idx]},
                                    avs_writedata, avs_byteenable));
    end
  end

  // Connection words, with a loopback bitmap kept beside them
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < tsi_pkg::CONN_DEPTH; i++) begin
        conn_mem[i] <= '0;
      end
      for (int i = 0; i < 16; i++) begin
        channel_loopback_map[i] <= '0;
      end
    end else if (wr_take && conn_hit) begin
      conn_mem[cidx] <= tsi_pkg::conn_word_t'(conn_new);
      channel_loopback_map[cidx[10:7]][cidx[6:0]] <= conn_new[15];
    end
  end

  // Per-stream receivers; shift is {offset, half} half periods
  for (genvar g = 0; g < 16; g++) begin : rx_lane
    assign half_shift[g] = {ofs_reg[g/4][4*(g%4)+1 +: 3],
                            ofs_reg[g/4][4*(g%4)] ^
                            ctrl[tsi_pkg::GCI_BIT]};
    stream_receiver u_rx (
      .clk        (clk),
      .rst        (rst),
      .pos        (pos),
      .shift      (shift),
      .half_shift (half_shift[g]),
      .rx_bit     (rx_last[g]),
      .loop_bit   (tx[g]),
      .channel_loopback_row   (channel_loopback_map[g]),
      .rd_chan    (rd_chan),
      .rd_const   (w.const_delay),
      .rd_byte    (rx_byte[g])
    );
  end

  // Fetch the word of stream step for the coming channel
  assign w        = conn_mem[{step, nxt_chan}];
  assign rd_chan  = w.source_channel_number & chan_mask(rate);
  assign sel_byte = w.processor_byte_select ?
                    {w.source_stream_number[0],
                     w.source_channel_number} :
                    rx_byte[w.source_stream_number];

  // Prefetch registers and control bit, one channel ahead
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        nxt_byte[i] <= 8'h00;
      end
      nxt_oe              <= 16'h0000;
      control_channel_out <= 1'b0;
    end else begin
      nxt_byte[step]      <= sel_byte;
      nxt_oe[step]        <= w.out_enable;
      control_channel_out <= w.control_channel_bit;
    end
  end

  // Channel boundary moves the prefetched set into play
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        cur_byte[i] <= 8'h00;
      end
      cur_oe <= 16'h0000;
    end else if (bnd) begin
      cur_byte <= nxt_byte;
      cur_oe   <= nxt_oe;
    end
  end

  // Bypass at the boundary so the first bit is not a cycle late
  for (genvar g = 0; g < 16; g++) begin : tx_sel
    assign out_byte[g] = bnd ? nxt_byte[g] : cur_byte[g];
    assign out_oe[g]   = bnd ? nxt_oe[g] : cur_oe[g];
  end

  // Serial outputs, most significant bit first
  always_ff @(posedge clk) begin
    for (int k = 0; k < 16; k++) begin
      if (rst) begin
        tx[k]      <= 1'b0;
        tx_oe_n[k] <= 1'b1;
      end else begin
        tx[k]      <= out_byte[k][tsi_pkg::LAST_BIT - bit_idx];
        tx_oe_n[k] <= !out_oe[k];
      end
    end
  end

  // Frame delay measurement on one stream
  assign meas_go = wr_take && ctrl_hit && avs_byteenable[0] &&
                   avs_writedata[tsi_pkg::MEAS_GO_BIT];
  assign rx_fall = rx_prev[meas_sel] && !rx_last[meas_sel];

  // A new request restarts a measurement that is under way
  always_ff @(posedge clk) begin
    if (rst) begin
      mstate     <= tsi_pkg::MEAS_IDLE;
      mcnt       <= 4'h0;
      meas_sel   <= 4'h0;
      meas_count <= 3'h0;
      meas_flag  <= 1'b1;
    end else if (meas_go) begin
      meas_sel <= avs_writedata[tsi_pkg::MEAS_SEL_LSB +: 4];
      mstate   <= tsi_pkg::MEAS_ARMED;
    end else begin
      case (mstate)
        tsi_pkg::MEAS_IDLE: begin
          mcnt <= 4'h0;
        end
        tsi_pkg::MEAS_ARMED: begin
          if (frame_start) begin
            mcnt   <= 4'h0;
            mstate <= tsi_pkg::MEAS_COUNT;
          end
        end
        tsi_pkg::MEAS_COUNT: begin
          // Half periods: upper bits whole count, low bit half
          if (rx_fall || mcnt == tsi_pkg::HALF_MAX) begin
            meas_count <= mcnt[3:1];
            meas_flag  <= !mcnt[0];
            mstate     <= tsi_pkg::MEAS_IDLE;
          end else begin
            mcnt <= mcnt + 4'h1;
          end
        end
        default: begin
          mstate <= tsi_pkg::MEAS_IDLE;
        end
      endcase
    end
  end

  wait_release_a: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest not raised after an access");

  meas_default_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> meas_flag && meas_count == 3'h0)
    else $error("measurement does not read zero shift after reset");

  meas_result_a: assert property (@(posedge clk) disable iff (rst)
    mstate == tsi_pkg::MEAS_COUNT && rx_fall && !meas_go |=>
    meas_flag == !$past(mcnt[0]) && meas_count == $past(mcnt[3:1]))
    else $error("measured delay does not match half period count");

  meas_limit_a: assert property (@(posedge clk) disable iff (rst)
    meas_count <= tsi_pkg::COUNT_MAX && mcnt <= tsi_pkg::HALF_MAX)
    else $error("measurement beyond four and a half periods");

  proc_byte_a: assert property (@(posedge clk) disable iff (rst)
    w.processor_byte_select |=> nxt_byte[$past(step)] ==
    $past({w.source_stream_number[0], w.source_channel_number}))
    else $error("processor byte not taken from connection word");

  switch_byte_a: assert property (@(posedge clk) disable iff (rst)
    !w.processor_byte_select |=> nxt_byte[$past(step)] ==
    $past(rx_byte[w.source_stream_number]))
    else $error("switched byte not taken from source stream");

  chan_mask_a: assert property (@(posedge clk) disable iff (rst)
    (rd_chan & ~chan_mask(rate)) == 7'h00)
    else $error("unused channel address bit reached data memory");

  oe_drive_a: assert property (@(posedge clk) disable iff (rst)
    bnd |=> tx_oe_n[0] == !$past(nxt_oe[0]) ##1
    (tx_oe_n[0] == !$past(cur_oe[0]) || $past(bnd)))
    else $error("output enable does not follow the channel word");

  cco_early_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> control_channel_out ==
    $past(conn_mem[{step, 7'((chan + 7'h01) & chan_mask(rate))}]
          .control_channel_bit))
    else $error("control bit not one channel ahead");
endmodule
`default_nettype wire

/* tdm_line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-end line: frame pulse each 4096 clocks, one known byte per channel
module tdm_line_partner (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Line setup: lateness in clocks, log2 cell length, lines held high
  input  wire logic [3:0]  delay,
  input  wire logic [2:0]  shift,
  input  wire logic        quiet,
  // Line outputs
  output logic      [11:0] pos,
  output logic             frame_pulse_input_n,
  output logic      [15:0] rx
);
  logic [11:0] t;

  // Byte of stream s, channel c; stream 8-15 differ from 0-7 on purpose
  function automatic logic line_bit(input logic [3:0]  s,
                                    input logic [11:0] tt,
                                    input logic [2:0]  sh);
    logic [6:0] c;
    logic [2:0] i;
    logic [7:0] b;
    c = 7'(tt >> (sh + 3'h3));
    i = 3'(tt >> sh);
    b = {s[2:0] ^ {2'h0, s[3]}, c[4:0]};
    return b[3'h7 - i];
  endfunction

  // Free-running frame position
  always_ff @(posedge clk) begin
    if (rst) pos <= 12'h001;
    else pos <= pos + 12'h001;
  end

  // Pulse is one clock low as each frame starts
  assign frame_pulse_input_n = (pos != 12'h000);
  assign t = pos - {8'h00, delay};

  // Late lines shift every cell; a quiet line never falls
  always_comb begin
    for (int s = 0; s < 16; s++) begin
      rx[s] = quiet | line_bit(4'(s), t, shift);
    end
  end
endmodule
`default_nettype wire

/* tdm_switch_connection_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tdm_switch_connection_control_tb;
  typedef struct packed {
    logic [3:0]  s;
    logic [6:0]  c;
    logic [15:0] w;
    logic [7:0]  b;
    logic        oe_n;
  } row_t;
  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic [13:0] avs_address    = 14'h0000;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        frame_pulse_input_n;
  logic [15:0] rx;
  logic [15:0] tx;
  logic [15:0] tx_oe_n;
  logic        control_channel_out;
  logic [11:0] pos;
  logic [3:0]  delay          = 4'h0;
  logic [2:0]  shift          = 3'h2;
  logic        quiet          = 1'b0;
  int          failures       = 0;
  int          n_tests        = 0;
  int          cycles         = 0;
  logic [31:0] rd;
  logic [7:0]  got;
  logic        got_oe_n;
  // Output stream/channel, word, expected byte and driver state
  row_t        rows [8] = '{
    '{4'h0, 7'h05, 16'h0903, 8'h43, 1'b0}, '{4'h1, 7'h06, 16'h2FB6, 8'hB6, 1'b0},
    '{4'h1, 7'h07, 16'h0103, 8'h00, 1'b1}, '{4'h3, 7'h07, 16'hA83C, 8'h3C, 1'b0},
    '{4'h5, 7'h09, 16'h1000, 8'h00, 1'b1}, '{4'h4, 7'h0A, 16'h0987, 8'h3C, 1'b0},
    '{4'h6, 7'h0C, 16'h4A89, 8'hA9, 1'b0}, '{4'h7, 7'h14, 16'h0C82, 8'h02, 1'b0}};

  always #25 clk = ~clk;

  tdm_switch_connection_control dut_u (.clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .frame_pulse_input_n, .rx, .tx, .tx_oe_n,
    .control_channel_out);
  tdm_line_partner line_u (.clk, .rst, .delay, .shift, .quiet, .pos,
    .frame_pulse_input_n, .rx);

  function automatic logic [13:0] conn_addr(input int s, input int c);
    return 14'h2000 | 14'((s * 128 + c) * 4);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low; reads land in rd
  task automatic bus(input logic wr, input logic [13:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wait_pos(input int p);
    do begin
      @(posedge clk);
      #1;
    end while (pos !== 12'(p));
  endtask

  // Samples each cell mid-way; device frame starts 3 clocks after pulse
  task automatic grab(input int s, input int c, input int sh);
    for (int i = 0; i < 8; i++) begin
      wait_pos(4 + ((c * 8 + i) << sh) + (1 << (sh - 1)));
      got[7 - i] = tx[s];
      if (i == 0) got_oe_n = tx_oe_n[s];
    end
  endtask

  // Hang guard, well above the roughly 62000 clocks the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(0, tsi_pkg::CTRL_OFS, 0, 4'hF);
    check(rd, tsi_pkg::CTRL_RESET);
    bus(0, tsi_pkg::OFFSET_OFS, 0, 4'hF);
    check(rd, 32'h00000000);
    bus(0, tsi_pkg::MEAS_OFS, 0, 4'hF);
    check(rd, 32'h00000008);
    bus(0, 14'h0100, 0, 4'hF);
    check(rd, tsi_pkg::UNMAPPED_DATA);
    bus(1, conn_addr(15, 127), 32'hFFFFFFFF, 4'h1);
    bus(0, conn_addr(15, 127), 0, 4'hF);
    check(rd, 32'h000000FF);
    $display("register test done");
    // Program and read back every row before any traffic check
    foreach (rows[k]) bus(1, conn_addr(rows[k].s, rows[k].c), 32'(rows[k].w), 4'hF);
    foreach (rows[k]) begin
      bus(0, conn_addr(rows[k].s, rows[k].c), 0, 4'hF);
      check(rd, 32'(rows[k].w));
    end
    repeat (4200) @(posedge clk);
    foreach (rows[k]) begin
      grab(rows[k].s, rows[k].c, 2);
      check(32'(got_oe_n), 32'(rows[k].oe_n));
      if (!rows[k].oe_n) check(32'(got), 32'(rows[k].b));
    end
    // Control bit of stream 5 channel 9 leaves in channel 8, step 5
    wait_pos(269);
    check(32'(control_channel_out), 32'h0);
    wait_pos(271);
    check(32'(control_channel_out), 32'h1);
    wait_pos(303);
    check(32'(control_channel_out), 32'h0);
    $display("switching test done");
    // Lines 2.5 periods late; offset 2 plus latch edge matches it
    delay <= 4'h5;
    bus(1, tsi_pkg::OFFSET_OFS, 32'h00005555, 4'hF);
    bus(1, tsi_pkg::CTRL_OFS, 32'h0000001A, 4'hF);
    repeat (8400) @(posedge clk);
    bus(0, tsi_pkg::MEAS_OFS, 0, 4'hF);
    check(rd, 32'h00000002);
    grab(0, 5, 2);
    check(32'(got), 32'h43);
    // Second format flips the half step: 4 clocks late now lines up
    delay <= 4'h4;
    bus(1, tsi_pkg::CTRL_OFS, 32'h00000006, 4'hF);
    repeat (4200) @(posedge clk);
    grab(0, 5, 2);
    check(32'(got), 32'h43);
    // A line that never falls measures the largest delay
    quiet <= 1'b1;
    bus(1, tsi_pkg::CTRL_OFS, 32'h0000001A, 4'hF);
    repeat (8400) @(posedge clk);
    bus(0, tsi_pkg::MEAS_OFS, 0, 4'hF);
    check(rd, 32'h00000004);
    $display("offset test done");
    // Slowest rate; offsets back to zero before the switching check
    quiet <= 1'b0;
    delay <= 4'h0;
    shift <= 3'h4;
    bus(1, tsi_pkg::OFFSET_OFS, 32'h00000000, 4'hF);
    bus(1, tsi_pkg::CTRL_OFS, 32'h00000000, 4'hF);
    bus(1, conn_addr(0, 2), 32'h00000943, 4'hF);
    repeat (4200) @(posedge clk);
    grab(0, 2, 4);
    check(32'(got), 32'h43);
    // Middle rate: same word, channel bit 6 must still be dropped
    shift <= 3'h3;
    bus(1, tsi_pkg::CTRL_OFS, 32'h00000001, 4'hF);
    repeat (4200) @(posedge clk);
    grab(0, 2, 3);
    check(32'(got), 32'h43);
    $display("rate test done");
    end_of_test();
  end
endmodule
`default_nettype wire
